// [core/protection_config_regs.sv]
// Operation
// - limit register: droop slope 7:5, temp-comp enable 4, current limit 3:0
// - droop code 0 is zero slope, steps of 0.39 up to 2.75 V/A/Ohm
// - current limit 0h 37%, 1h 47%, Bh 140%; codes above Bh act as Bh
// - absolute thresholds follow every change of the output setpoint
// - type register bits 5:0 pick latching per protection, 1 latches
// - type bit 7 enables tracking fault, bit 6 enables phase error
// - non-latching trip retries start-up every 130 ms until cause clears
// - each restart ramps the output, never steps it to setpoint
// - latching trip turns converter off with no automatic restart
// - latched restart needs 130 ms, cause gone, and flag clear or command cycle
// - each active fault reads as a 0 bit in the status flags
// - temp-comp raises current limit above room temperature to hold it flat
//
`timescale 1ns/1ps
module protection_config_regs #(
  parameter int VW = 13,
  parameter int RESTART_CYCLES = prot_cfg_pkg::RESTART_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic [1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [VW-1:0] i_vout_setpoint,
  input wire logic [7:0] i_temp_c,
  input wire logic i_turn_on,
  input wire logic [5:0] i_fault_raw,
  input wire logic i_ramp_done,
  output logic [11:0] o_droop_slope_mv,
  output logic [7:0] o_ilim_pct,
  output logic [VW-1:0] o_ov_thresh,
  output logic [VW-1:0] o_uv_thresh,
  output logic [VW-1:0] o_pg_low_thresh,
  output logic [VW-1:0] o_pg_high_thresh,
  output logic o_conv_en,
  output logic o_ramp_req,
  output logic [5:0] o_protection_flags
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] limit_cfg_q;
  logic [7:0] thresh_cfg_q;
  logic [7:0] type_cfg_q;
  logic wr_limit;
  logic wr_thresh;
  logic wr_type;
  logic wr_flags;
  assign wr_limit = i_reg_wr && (i_reg_addr == prot_cfg_pkg::ADDR_LIMIT);
  assign wr_thresh = i_reg_wr && (i_reg_addr == prot_cfg_pkg::ADDR_THRESH);
  assign wr_type = i_reg_wr && (i_reg_addr == prot_cfg_pkg::ADDR_TYPE);
  assign wr_flags = i_reg_wr && (i_reg_addr == prot_cfg_pkg::ADDR_FLAGS);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      limit_cfg_q <= prot_cfg_pkg::LIMIT_RESET;
      thresh_cfg_q <= prot_cfg_pkg::THRESH_RESET;
      type_cfg_q <= prot_cfg_pkg::TYPE_RESET;
    end
    else if (i_ce)
    begin
      if (wr_limit)
        limit_cfg_q <= i_reg_wdata;
      if (wr_thresh)
        thresh_cfg_q <= i_reg_wdata & prot_cfg_pkg::THRESH_MASK;
      if (wr_type)
        type_cfg_q <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic [2:0] droop_slope_sel;
  logic oc_temp_comp_en;
  logic [3:0] current_limit_level;
  logic pwrgood_low_sel;
  logic [1:0] overvolt_level;
  logic [1:0] undervolt_level;
  logic track_fault_en;
  logic phase_err_en;
  assign droop_slope_sel = limit_cfg_q[prot_cfg_pkg::SLOPE_LSB +: 3];
  assign oc_temp_comp_en = limit_cfg_q[prot_cfg_pkg::TCOMP_BIT];
  assign current_limit_level = limit_cfg_q[3:0];
  assign pwrgood_low_sel = thresh_cfg_q[prot_cfg_pkg::PGLOW_BIT];
  assign overvolt_level = thresh_cfg_q[prot_cfg_pkg::OV_LSB +: 2];
  assign undervolt_level = thresh_cfg_q[1:0];
  assign track_fault_en = type_cfg_q[prot_cfg_pkg::TRACK_EN_BIT];
  assign phase_err_en = type_cfg_q[prot_cfg_pkg::PHASE_EN_BIT];

  // ----------------------------------------------------------------
  // current limit with temperature compensation
  // ----------------------------------------------------------------
  // a coarse linear boost keeps the trip current flat as the sense element warms
  logic [7:0] ilim_base;
  logic [7:0] temp_excess;
  logic [7:0] ilim_comp;
  assign ilim_base = prot_cfg_pkg::ilim_pct(current_limit_level);
  assign temp_excess = (i_temp_c > prot_cfg_pkg::ROOM_TEMP_C) ?
    (i_temp_c - prot_cfg_pkg::ROOM_TEMP_C) : 8'h00;
  assign ilim_comp = oc_temp_comp_en ?
    ilim_base + (temp_excess >> prot_cfg_pkg::TCOMP_SHIFT) : ilim_base;

  // ----------------------------------------------------------------
  // absolute thresholds from the live setpoint
  // ----------------------------------------------------------------
  logic [7:0] pct_sel [4];
  logic [VW-1:0] scaled [4];
  assign pct_sel[0] = prot_cfg_pkg::ov_pct(overvolt_level);
  assign pct_sel[1] = prot_cfg_pkg::uv_pct(undervolt_level);
  assign pct_sel[2] = pwrgood_low_sel ? prot_cfg_pkg::PCT_PG_LOW_95 :
    prot_cfg_pkg::PCT_PG_LOW_90;
  assign pct_sel[3] = prot_cfg_pkg::PCT_PG_HIGH;

  for (genvar g = 0; g < 4; g++)
  begin : g_scale
    pct_scale #(.VW(VW)) u_scale (
      .i_value(i_vout_setpoint),
      .i_pct(pct_sel[g]),
      .o_scaled(scaled[g])
    );
  end

  // ----------------------------------------------------------------
  // fault handling
  // ----------------------------------------------------------------
  prot_cfg_pkg::fsm_state_t state_q;
  prot_cfg_pkg::fsm_state_t state_d;
  logic [5:0] fault_en;
  logic [5:0] fault_act;
  logic [5:0] cause_q;
  logic [5:0] flag_q;
  logic release_q;
  logic trip;
  logic trip_latch;
  logic cause_active;
  logic flag_clr_hit;
  logic timer_done;
  logic timer_start;
  logic powered;

  assign fault_en = {track_fault_en, 4'hf, phase_err_en};
  assign fault_act = i_fault_raw & fault_en;
  assign powered = (state_q == prot_cfg_pkg::ramp) || (state_q == prot_cfg_pkg::run);
  assign trip = powered && (|fault_act);
  assign trip_latch = |(fault_act & type_cfg_q[5:0]);
  assign cause_active = |(i_fault_raw & cause_q);
  assign flag_clr_hit = wr_flags && (|(i_reg_wdata[5:0] & cause_q));
  assign timer_start = trip;

  restart_timer #(.CYCLES(RESTART_CYCLES)) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_start(timer_start),
    .o_done(timer_done)
  );

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      prot_cfg_pkg::idle:
        if (i_turn_on)
          state_d = prot_cfg_pkg::ramp;
      prot_cfg_pkg::ramp, prot_cfg_pkg::run:
        if (trip)
          state_d = trip_latch ? prot_cfg_pkg::latched_off : prot_cfg_pkg::retry_wait;
        else if (!i_turn_on)
          state_d = prot_cfg_pkg::idle;
        else if (i_ramp_done)
          state_d = prot_cfg_pkg::run;
      prot_cfg_pkg::retry_wait:
        if (!i_turn_on)
          state_d = prot_cfg_pkg::idle;
        else if (timer_done)
          state_d = prot_cfg_pkg::ramp;
      prot_cfg_pkg::latched_off:
        if (timer_done && !cause_active && release_q && i_turn_on)
          state_d = prot_cfg_pkg::ramp;
      default:
        state_d = prot_cfg_pkg::idle;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_q <= prot_cfg_pkg::idle;
      cause_q <= 6'h00;
      release_q <= 1'b0;
      flag_q <= 6'h00;
    end
    else if (i_ce)
    begin
      state_q <= state_d;
      if (trip)
        cause_q <= fault_act;
      // a command cycle or a flag clear arms the latched release
      if (trip)
        release_q <= 1'b0;
      else if (flag_clr_hit || !i_turn_on)
        release_q <= 1'b1;
      // a live fault wins over a clear in the same cycle
      flag_q <= fault_act | (flag_q & ~(wr_flags ? i_reg_wdata[5:0] : 6'h00));
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;
  assign rdata_d = (i_reg_addr == prot_cfg_pkg::ADDR_LIMIT) ? limit_cfg_q :
    (i_reg_addr == prot_cfg_pkg::ADDR_THRESH) ? thresh_cfg_q :
    (i_reg_addr == prot_cfg_pkg::ADDR_TYPE) ? type_cfg_q :
    {2'h3, ~flag_q};

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= 8'h00;
      o_droop_slope_mv <= 12'h000;
      o_ilim_pct <= 8'h00;
      o_ov_thresh <= '0;
      o_uv_thresh <= '0;
      o_pg_low_thresh <= '0;
      o_pg_high_thresh <= '0;
      o_conv_en <= 1'b0;
      o_ramp_req <= 1'b0;
      o_protection_flags <= 6'h3f;
    end
    else if (i_ce)
    begin
      o_reg_rdata <= rdata_d;
      o_droop_slope_mv <= prot_cfg_pkg::slope_mv(droop_slope_sel);
      o_ilim_pct <= ilim_comp;
      o_ov_thresh <= scaled[0];
      o_uv_thresh <= scaled[1];
      o_pg_low_thresh <= scaled[2];
      o_pg_high_thresh <= scaled[3];
      o_conv_en <= (state_d == prot_cfg_pkg::ramp) || (state_d == prot_cfg_pkg::run);
      o_ramp_req <= (state_d == prot_cfg_pkg::ramp);
      o_protection_flags <= ~(fault_act | (flag_q & ~(wr_flags ? i_reg_wdata[5:0] : 6'h00)));
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  limit_write_a:
    assert property (i_ce && wr_limit |=> limit_cfg_q == $past(i_reg_wdata))
    else $error("limit register did not take the write");

  slope_decode_a:
    assert property (i_ce && limit_cfg_q[7:5] == 3'h7 && wr_limit == 1'b0
      |=> o_droop_slope_mv == 12'habe)
    else $error("top droop code not decoded to full slope");

  ilim_clamp_a:
    assert property (i_ce && current_limit_level > prot_cfg_pkg::ILIM_MAX_CODE
      && !oc_temp_comp_en |=> o_ilim_pct == 8'h8c)
    else $error("current limit above top code not clamped");

  thresh_upper_a:
    assert property (o_reg_rdata[7:5] == 3'h0 || $past(i_reg_addr) != prot_cfg_pkg::ADDR_THRESH
      || !$past(i_ce))
    else $error("threshold upper bits read nonzero");

  ov_follow_a:
    assert property (i_ce && overvolt_level == 2'h0
      |=> o_ov_thresh == VW'((($past(i_vout_setpoint) * 110) / 100)))
    else $error("overvoltage threshold did not follow setpoint");

  retry_hold_a:
    assert property (state_q == prot_cfg_pkg::retry_wait && !timer_done
      |=> state_q != prot_cfg_pkg::ramp)
    else $error("restart before the retry interval");

  latched_off_a:
    assert property (i_ce && trip && trip_latch
      |=> !o_conv_en && state_q == prot_cfg_pkg::latched_off)
    else $error("latching trip left converter on");

  latched_release_a:
    assert property (state_q == prot_cfg_pkg::latched_off ##1 state_q == prot_cfg_pkg::ramp
      |-> $past(timer_done) && $past(release_q) && !$past(cause_active))
    else $error("latched restart without release conditions");

  flag_low_a:
    assert property (i_ce && fault_act[1] |=> !o_protection_flags[1] && flag_q[1])
    else $error("active fault not shown as zero flag");

  restart_ramp_a:
    assert property (i_ce && state_d == prot_cfg_pkg::ramp |=> o_ramp_req && o_conv_en)
    else $error("restart did not request a ramp");

  retry_cov: cover property (state_q == prot_cfg_pkg::retry_wait ##1 state_q == prot_cfg_pkg::ramp);
  latch_cov: cover property (state_q == prot_cfg_pkg::latched_off ##1 state_q == prot_cfg_pkg::ramp);
  run_cov: cover property (state_q == prot_cfg_pkg::ramp ##1 state_q == prot_cfg_pkg::run);

endmodule : protection_config_regs

// [core/prot_cfg_pkg.sv]
package prot_cfg_pkg;

  // ----------------------------------------------------------------
  // register select codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_LIMIT = 2'h0;
  localparam logic [1:0] ADDR_THRESH = 2'h1;
  localparam logic [1:0] ADDR_TYPE = 2'h2;
  localparam logic [1:0] ADDR_FLAGS = 2'h3;
  localparam logic [7:0] LIMIT_RESET = 8'h1b;
  localparam logic [7:0] THRESH_RESET = 8'h08;
  localparam logic [7:0] TYPE_RESET = 8'h43;
  localparam logic [7:0] THRESH_MASK = 8'h1f;
  localparam logic [7:0] FLAGS_IDLE = 8'hff;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SLOPE_LSB = 5;
  localparam int TCOMP_BIT = 4;
  localparam int PGLOW_BIT = 4;
  localparam int OV_LSB = 2;
  localparam int TRACK_EN_BIT = 7;
  localparam int PHASE_EN_BIT = 6;
  localparam int NFAULT = 6;
  localparam logic [3:0] ILIM_MAX_CODE = 4'hb;

  // ----------------------------------------------------------------
  // percentages of the setpoint and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] PCT_PG_HIGH = 8'h6e;
  localparam logic [7:0] PCT_PG_LOW_95 = 8'h5f;
  localparam logic [7:0] PCT_PG_LOW_90 = 8'h5a;
  localparam logic [7:0] PCT_ILIM_MAX = 8'h8c;
  localparam int RESTART_MS = 130;
  localparam int CLK_NS = 25;
  localparam int RESTART_CYCLES = RESTART_MS * 1000000 / CLK_NS;
  localparam logic [7:0] ROOM_TEMP_C = 8'h19;
  localparam int TCOMP_SHIFT = 2;

  typedef enum logic [2:0] {
    idle = 3'h0,
    ramp = 3'h1,
    run = 3'h2,
    retry_wait = 3'h3,
    latched_off = 3'h4
  } fsm_state_t;

  // droop slope in mV/A/Ohm
  function automatic logic [11:0] slope_mv(input logic [2:0] code);
    logic [11:0] r;
    r = 12'h000;
    unique case (code)
      3'h0: r = 12'h000;
      3'h1: r = 12'h186;
      3'h2: r = 12'h30c;
      3'h3: r = 12'h49c;
      3'h4: r = 12'h622;
      3'h5: r = 12'h7a8;
      3'h6: r = 12'h92e;
      3'h7: r = 12'habe;
    endcase
    return r;
  endfunction : slope_mv

  // codes above the top step act as the top step
  function automatic logic [7:0] ilim_pct(input logic [3:0] code);
    logic [7:0] r;
    r = PCT_ILIM_MAX;
    unique case (code)
      4'h0: r = 8'h25;
      4'h1: r = 8'h2f;
      4'h2: r = 8'h38;
      4'h3: r = 8'h41;
      4'h4: r = 8'h4b;
      4'h5: r = 8'h54;
      4'h6: r = 8'h5d;
      4'h7: r = 8'h67;
      4'h8: r = 8'h70;
      4'h9: r = 8'h79;
      4'ha: r = 8'h83;
      default: r = PCT_ILIM_MAX;
    endcase
    return r;
  endfunction : ilim_pct

  function automatic logic [7:0] ov_pct(input logic [1:0] code);
    return (code == 2'h0) ? 8'h6e : (code == 2'h1) ? 8'h78 : 8'h82;
  endfunction : ov_pct

  function automatic logic [7:0] uv_pct(input logic [1:0] code);
    return 8'h4b + {4'h0, code, 2'h0} + {6'h00, code};
  endfunction : uv_pct

endpackage : prot_cfg_pkg

// [core/pct_scale.sv]
`timescale 1ns/1ps
// scales a setpoint by a whole percentage, truncating
module pct_scale #(
  parameter int VW = 13
) (
  input wire logic [VW-1:0] i_value,
  input wire logic [7:0] i_pct,
  output logic [VW-1:0] o_scaled
);
  localparam int PW = VW + 8;
  logic [PW-1:0] prod;
  logic [PW-1:0] quot;
  assign prod = PW'(i_value) * PW'(i_pct);
  assign quot = prod / PW'(100);
  assign o_scaled = quot[VW-1:0];
endmodule : pct_scale

// [core/restart_timer.sv]
`timescale 1ns/1ps
// one-shot down counter; o_done holds once the interval has elapsed
module restart_timer #(
  parameter int CYCLES = 5200000
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_start,
  output logic o_done
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic armed_q;
  assign o_done = armed_q && (cnt_q == '0);
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      cnt_q <= '0;
      armed_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_start)
      begin
        cnt_q <= CW'(CYCLES - 1);
        armed_q <= 1'b1;
      end
      else if (cnt_q != '0)
        cnt_q <= cnt_q - CW'(1);
    end
  end
endmodule : restart_timer

// [dv/host_model.sv]
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic [1:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  initial
  begin
    o_reg_wr = 1'b0;
    o_reg_addr = 2'h0;
    o_reg_wdata = 8'h00;
  end

  // ----------------------------------------------------------------
  // register access, called just after a rising edge
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_reg_wr = 1'b0;
    // released data shows the inverse so a stale value cannot pass
    o_reg_wdata = ~d;
    // one idle edge so a following write never re-raises the strobe in this time step
    @(posedge i_clk_sys);
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    o_reg_addr = a;
    repeat (2) @(posedge i_clk_sys);
    #1;
    d = i_reg_rdata;
  endtask : rd_reg

  task automatic release_latch();
    wr_reg(prot_cfg_pkg::ADDR_FLAGS, 8'hff);
  endtask : release_latch
endmodule : host_model

// [dv/tb_protection_config_regs.sv]
`timescale 1ns/1ps
module tb_protection_config_regs;
  // short restart interval keeps the run brief
  localparam int RC = 20;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic ce = 1'b1;
  logic turn_on = 1'b0;
  logic ramp_done = 1'b0;
  logic [5:0] fault_raw = 6'h00;
  logic [7:0] temp_c = 8'h19;
  logic [12:0] setpoint = 13'h03e8;
  logic reg_wr;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic [11:0] droop;
  logic [7:0] ilim;
  logic [12:0] ov, uv, pgl, pgh;
  logic conv_en, ramp_req;
  logic [5:0] flags;
  int fail_count = 0;
  int total_checks = 0;
  int slope_tab[8] = '{0, 390, 780, 1180, 1570, 1960, 2350, 2750};
  int ilim_tab[16] = '{37, 47, 56, 65, 75, 84, 93, 103, 112, 121, 131, 140, 140, 140, 140, 140};
  int ov_tab[4] = '{110, 120, 130, 130};
  int uv_tab[4] = '{75, 80, 85, 90};

  always #12.5 i_clk_sys = ~i_clk_sys;

  host_model i_host_model (.i_clk_sys(i_clk_sys), .i_reg_rdata(reg_rdata), .o_reg_wr(reg_wr),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

  protection_config_regs #(.VW(13), .RESTART_CYCLES(RC)) i_protection_config_regs (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(ce), .i_reg_wr(reg_wr),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_vout_setpoint(setpoint), .i_temp_c(temp_c), .i_turn_on(turn_on),
    .i_fault_raw(fault_raw), .i_ramp_done(ramp_done), .o_droop_slope_mv(droop),
    .o_ilim_pct(ilim), .o_ov_thresh(ov), .o_uv_thresh(uv), .o_pg_low_thresh(pgl),
    .o_pg_high_thresh(pgh), .o_conv_en(conv_en), .o_ramp_req(ramp_req),
    .o_protection_flags(flags));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic rdc(input string name, input logic [1:0] a, input logic [7:0] e);
    i_host_model.rd_reg(a, rd);
    check(name, 16'(rd), 16'(e));
  endtask : rdc

  // a wait that runs out of its bound ends the run
  task automatic wait_for(input string name, input logic which, input logic v, input int bound);
    int n;
    n = 0;
    while (((which ? ramp_req : conv_en) !== v) && n < bound)
    begin
      cyc(1);
      n++;
    end
    check(name, 16'(which ? ramp_req : conv_en), 16'(v));
    if ((which ? ramp_req : conv_en) !== v)
      print_verdict();
  endtask : wait_for

  task automatic go_run();
    turn_on = 1'b1;
    wait_for("start", 1'b0, 1'b1, RC + 20);
    ramp_done = 1'b1;
    cyc(2);
    ramp_done = 1'b0;
  endtask : go_run

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    cyc(20);
    i_reset = 1'b0;
    cyc(2);
    rdc("limit rst", prot_cfg_pkg::ADDR_LIMIT, prot_cfg_pkg::LIMIT_RESET);
    rdc("thresh rst", prot_cfg_pkg::ADDR_THRESH, prot_cfg_pkg::THRESH_RESET);
    rdc("type rst", prot_cfg_pkg::ADDR_TYPE, prot_cfg_pkg::TYPE_RESET);
    rdc("flags rst", prot_cfg_pkg::ADDR_FLAGS, prot_cfg_pkg::FLAGS_IDLE);
    check("ilim rst", 16'(ilim), 16'h008c);
    $display("test reset done");

    for (int i = 0; i < 16; i++)
    begin
      i_host_model.wr_reg(prot_cfg_pkg::ADDR_LIMIT, {i[2:0], 1'b0, i[3:0]});
      cyc(2);
      check("slope", 16'(droop), 16'(slope_tab[i[2:0]]));
      check("ilim", 16'(ilim), 16'(ilim_tab[i]));
      rdc("limit rd", prot_cfg_pkg::ADDR_LIMIT, {i[2:0], 1'b0, i[3:0]});
    end
    i_host_model.wr_reg(prot_cfg_pkg::ADDR_LIMIT, 8'h11);
    temp_c = 8'h41;
    cyc(3);
    check("ilim hot", 16'(ilim), 16'h0039);
    temp_c = 8'h14;
    cyc(3);
    check("ilim cool", 16'(ilim), 16'h002f);
    temp_c = 8'h19;
    // a write while the clock enable is low must not land
    ce = 1'b0;
    i_host_model.wr_reg(prot_cfg_pkg::ADDR_LIMIT, 8'he0);
    ce = 1'b1;
    rdc("limit frozen", prot_cfg_pkg::ADDR_LIMIT, 8'h11);
    check("slope frozen", 16'(droop), 16'h0000);
    $display("test limit done");

    for (int i = 0; i < 32; i++)
    begin
      i_host_model.wr_reg(prot_cfg_pkg::ADDR_THRESH, {3'h7, i[4:0]});
      cyc(2);
      check("pg low", 16'(pgl), i[4] ? 16'h03b6 : 16'h0384);
      check("ov", 16'(ov), 16'(10 * ov_tab[i[3:2]]));
      check("uv", 16'(uv), 16'(10 * uv_tab[i[1:0]]));
      check("pg high", 16'(pgh), 16'h044c);
      rdc("thresh rd", prot_cfg_pkg::ADDR_THRESH, {3'h0, i[4:0]});
    end
    setpoint = 13'h07d0;
    cyc(3);
    check("ov moved", 16'(ov), 16'h0a28);
    check("uv moved", 16'(uv), 16'h0708);
    check("pg moved", 16'(pgl), 16'h076c);
    $display("test thresholds done");

    go_run();
    fault_raw = 6'h04;
    wait_for("uv trip", 1'b0, 1'b0, 4);
    check("uv flag", 16'(flags), 16'h003b);
    cyc(RC - 6);
    check("no early retry", 16'(conv_en), 16'h0000);
    wait_for("retry 1", 1'b0, 1'b1, 12);
    check("retry ramps", 16'(ramp_req), 16'h0001);
    wait_for("retrip", 1'b0, 1'b0, 4);
    fault_raw = 6'h00;
    cyc(RC - 6);
    check("still waiting", 16'(conv_en), 16'h0000);
    wait_for("retry 2", 1'b1, 1'b1, 12);
    go_run();
    cyc(RC + 5);
    check("stays on", 16'(conv_en), 16'h0001);
    i_host_model.release_latch();
    $display("test retry done");

    fault_raw = 6'h20;
    cyc(8);
    check("track off", 16'(conv_en), 16'h0001);
    fault_raw = 6'h00;
    i_host_model.wr_reg(prot_cfg_pkg::ADDR_TYPE, 8'h83);
    fault_raw = 6'h01;
    cyc(8);
    check("phase off", 16'(conv_en), 16'h0001);
    fault_raw = 6'h00;
    $display("test disable done");

    for (int b = 0; b < 6; b++)
    begin
      i_host_model.wr_reg(prot_cfg_pkg::ADDR_TYPE, 8'hc0 | (8'h01 << b));
      rdc("type rd", prot_cfg_pkg::ADDR_TYPE, 8'hc0 | (8'h01 << b));
      go_run();
      fault_raw = 6'h01 << b;
      wait_for("latch trip", 1'b0, 1'b0, 4);
      rdc("flags rd", prot_cfg_pkg::ADDR_FLAGS, {2'b11, ~(6'h01 << b)});
      fault_raw = 6'h00;
      if (b % 2 == 0)
      begin
        cyc(RC + 10);
        check("held off", 16'(conv_en), 16'h0000);
        i_host_model.release_latch();
      end
      else
      begin
        turn_on = 1'b0;
        cyc(2);
        turn_on = 1'b1;
        cyc(RC - 12);
        check("early on", 16'(conv_en), 16'h0000);
      end
      wait_for("relatch on", 1'b0, 1'b1, 20);
      i_host_model.release_latch();
    end
    $display("test latching done");
    print_verdict();
  end
endmodule : tb_protection_config_regs
